// *** dv/ops_host_props.sv ***
module ops_host_props #(
	parameter logic [ops_pkg::WAIT_W-1:0] OFF_GAP_CYC = 20,
	parameter int                         HALF_CYC    = 8
) (
	// clock and reset
	input wire logic               clk,
	input wire logic               rstn,
	// display module pins
	input wire ops_pkg::ops_pins_t panel_pins
);
	// ------------------------------------------------------------
	// helper logic
	// ------------------------------------------------------------
	localparam int RST_MIN = 150;
	// a zero gap count always fails the unsigned compare; one cycle of slack on a nonzero count
	localparam int GAP_MIN = int'(OFF_GAP_CYC) - 1;
	ops_pkg::ops_pins_t         p;
	logic [7:0]                 low_q;
	logic [7:0]                 sh_q;
	logic [7:0]                 hi_q;
	logic [ops_pkg::WAIT_W-1:0] gap_q;
	logic                       sclk_q;
	logic                       dc_q;
	assign p = panel_pins;
	// low time counts only with logic supply up, as the pulse is timed from it
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			low_q <= '0;
		else if (p.panel_reset_line_n || !p.logic_supply_en)
			low_q <= '0;
		else if (low_q != 8'hff)
			low_q <= low_q + 8'h01;
	end
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			gap_q <= '0;
		else if (p.panel_supply_en)
			gap_q <= '0;
		else if (p.logic_supply_en)
			gap_q <= gap_q + 1'b1;
	end
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			sclk_q <= 1'b0;
		else
			sclk_q <= p.serial_clk;
	end
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			hi_q <= '0;
		else if (p.serial_clk)
			hi_q <= hi_q + 8'h01;
		else
			hi_q <= '0;
	end
	// last byte on the wire, kept for the power-down order
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sh_q <= '0;
			dc_q <= 1'b0;
		end
		else if (p.serial_clk && !sclk_q && !p.chip_sel_n)
		begin
			sh_q <= {sh_q[6:0], p.serial_data_input};
			dc_q <= p.cmd_data_sel;
		end
	end
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	a_vcc_needs_vdd: assert property (
		p.panel_supply_en |-> p.logic_supply_en)
		else $error("panel supply on without logic supply");
	a_reset_low_len: assert property (
		$rose(p.panel_reset_line_n) |-> low_q >= RST_MIN)
		else $error("reset line low too short");
	a_vcc_after_reset: assert property (
		$rose(p.panel_supply_en) |-> low_q >= RST_MIN)
		else $error("panel supply too soon after reset low");
	a_off_after_cmd: assert property (
		$fell(p.panel_supply_en) |-> sh_q == 8'hae && !dc_q)
		else $error("panel supply off before display off");
	a_vdd_off_gap: assert property (
		$fell(p.logic_supply_en) |-> gap_q >= GAP_MIN && !p.panel_supply_en)
		else $error("logic supply off too early");
	a_frame_powered: assert property (
		!p.chip_sel_n |-> p.logic_supply_en && p.panel_reset_line_n)
		else $error("frame while module unpowered or in reset");
	a_dc_in_frame: assert property (
		!p.chip_sel_n && !$past(p.chip_sel_n) |-> $stable(p.cmd_data_sel))
		else $error("select line moved inside a frame");
	a_sclk_in_frame: assert property (
		p.serial_clk |-> !p.chip_sel_n && $stable(p.serial_data_input))
		else $error("serial clock high outside frame or data moved");
	a_sclk_half: assert property (
		$fell(p.serial_clk) |-> hi_q == 8'(HALF_CYC))
		else $error("serial clock high time wrong");
endmodule // ops_host_props

bind ops_host ops_host_props #(.OFF_GAP_CYC(OFF_GAP_CYC),
	.HALF_CYC(HALF_CYC)) u_props (
	.clk(clk), .rstn(rstn), .panel_pins(panel_pins));

// *** dv/ops_host_tb.sv ***
module ops_host_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [ops_pkg::WAIT_W-1:0] CYC = 20;
	logic               clk;
	logic               rstn;
	logic               psel;
	logic               penable;
	logic               pwrite;
	logic               pready;
	logic               pslverr;
	logic               err;
	logic [11:0]        paddr;
	logic [31:0]        pwdata;
	logic [31:0]        prdata;
	logic [31:0]        rd;
	logic [31:0]        x;
	logic [31:0]        ex;
	ops_pkg::ops_pins_t pins;
	int                 error_cnt = 0;
	int                 num_checks = 0;
	logic [7:0] rows [24] = '{8'hae, 8'hd5, 8'hf1, 8'ha8, 8'h3f, 8'hd9,
		8'hf1, 8'h20, 8'h02, 8'ha0, 8'hc8, 8'hda, 8'h12, 8'hd8, 8'h00,
		8'h81, 8'hcf, 8'hb0, 8'hd3, 8'h00, 8'ha6, 8'ha4, 8'hdb, 8'h3c};

	// a short link half period keeps the full clear inside the run budget
	ops_host #(.VDD_SETL_CYC(CYC), .VCC_SETL_CYC(CYC), .DISP_ON_CYC(CYC),
		.OFF_GAP_CYC(CYC), .HALF_CYC(2)) dut_u (.clk(clk), .rstn(rstn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .panel_pins(pins));
	ops_panel_model #(.ON_LAT(20)) pm_u (.clk(clk), .pins(pins));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// answer is taken at the rising edge where pready is seen high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_state(input logic [3:0] s);
		int i;
		i = 0;
		do
		begin
			repeat (100) @(posedge clk);
			apb(1'b0, ops_pkg::REG_STATUS, '0);
			i++;
		end while (rd[3:0] !== s && i < 3000);
	endtask
	task automatic print_verdict;
		if (error_cnt == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial
	begin
		repeat (80000) @(posedge clk);
		error_cnt++;
		print_verdict();
	end
	initial
	begin
		{psel, penable, pwrite, rstn} = '0;
		paddr = '0;
		pwdata = '0;
		repeat (12) @(posedge clk);
		chk(32'(pins), 32'h08);
		rstn <= 1'b1;
		apb(1'b0, 12'h00c, '0);
		chk(32'(err), 32'h1);
		apb(1'b1, ops_pkg::REG_CTRL, 32'h2);
		apb(1'b1, ops_pkg::REG_TX, 32'h1a5);
		apb(1'b0, ops_pkg::REG_STATUS, '0);
		chk(32'(rd[11:0]), 32'h0);
		apb(1'b1, ops_pkg::REG_CTRL, 32'h1);
		apb(1'b1, ops_pkg::REG_CTRL, 32'h1);
		wait_state(ops_pkg::S_ON);
		chk(32'(rd[11:0]), 32'h3c8);
		chk(pm_u.n_q, 1073);
		// ordinary cases: one row per byte of the set-up stream
		for (int i = 0; i < 24; i++)
		begin
			x = 32'(pm_u.log_q[i]);
			ex = 32'(rows[i]);
			if (i < 9)
				chk(x, ex);
			else
				chk(x, ex);
		end
		for (int pg = 0; pg < 8; pg++)
			for (int k = 0; k < 131; k++)
			begin
				ex = (k == 0) ? 32'h0b0 + 32'(pg) : (k == 1) ? 32'h0 :
					(k == 2) ? 32'h010 : 32'h100;
				chk(32'(pm_u.log_q[24 + pg * 131 + k]), ex);
			end
		chk(32'(pm_u.log_q[1072]), 32'h0af);
		chk(32'(pm_u.drive_on_q), 32'h1);
		chk(32'(pm_u.contrast_q), 32'hcf);
		// first byte launches at once, second waits, third is dropped
		apb(1'b1, ops_pkg::REG_TX, 32'h1a5);
		apb(1'b1, ops_pkg::REG_TX, 32'h1c3);
		apb(1'b1, ops_pkg::REG_TX, 32'h05a);
		apb(1'b0, ops_pkg::REG_TX, '0);
		chk(32'(rd[8:0]), 32'h1c3);
		apb(1'b0, ops_pkg::REG_STATUS, '0);
		chk(32'(rd[11:10]), 32'h3);
		repeat (400) @(posedge clk);
		apb(1'b0, ops_pkg::REG_STATUS, '0);
		chk(32'(rd[11:10]), 32'h0);
		chk(pm_u.n_q, 1075);
		chk(32'(pm_u.log_q[1073]), 32'h1a5);
		chk(32'(pm_u.log_q[1074]), 32'h1c3);
		apb(1'b1, ops_pkg::REG_CTRL, 32'h2);
		wait_state(ops_pkg::S_OFF);
		chk(32'(rd[11:0]), 32'h0);
		chk(32'(pm_u.log_q[1075]), 32'h0ae);
		chk(32'(pm_u.drive_on_q), 32'h0);
		repeat (200) @(posedge clk);
		chk(32'(pm_u.contrast_q), 32'h7f);
		print_verdict();
	end
endmodule // ops_host_tb

// *** dv/ops_panel_model.sv ***
module ops_panel_model #(
	parameter int         ON_LAT       = 20,
	parameter int         RST_MIN      = 150,
	parameter logic [7:0] CONTRAST_DEF = 8'h7f,
	parameter logic       STRAP        = 1'b0
) (
	// clock
	input wire logic               clk,
	// host pins
	input wire ops_pkg::ops_pins_t pins
);
	localparam logic [7:0] I2C_ADDR = STRAP ? 8'h7a : 8'h78;
	logic [8:0] log_q [1100];
	int         n_q = 0;
	int         bits_q = 0;
	int         rlow_q = 0;
	int         on_q = 0;
	logic       sclk_q = 1'b0;
	logic       par_q = 1'b0;
	logic       drive_on_q = 1'b0;
	logic [7:0] sh_q = '0;
	logic [7:0] contrast_q = CONTRAST_DEF;
	logic [7:0] nb;
	always @(posedge clk)
	begin
		sclk_q <= pins.serial_clk;
		rlow_q <= pins.panel_reset_line_n ? 0 : rlow_q + 1;
		if (rlow_q == RST_MIN)
		begin
			contrast_q <= CONTRAST_DEF;
			drive_on_q <= 1'b0;
		end
		if (on_q == ON_LAT)
			drive_on_q <= 1'b1;
		on_q <= (on_q > 0 && on_q < ON_LAT) ? on_q + 1 : 0;
		if (pins.chip_sel_n)
			bits_q <= 0;
		else if (pins.serial_clk && !sclk_q)
		begin
			nb = {sh_q[6:0], pins.serial_data_input};
			sh_q <= nb;
			bits_q <= (bits_q == 7) ? 0 : bits_q + 1;
			if (bits_q == 7)
			begin
				log_q[n_q] <= {pins.cmd_data_sel, nb};
				n_q <= n_q + 1;
				if (!pins.cmd_data_sel)
				begin
					par_q <= (nb == 8'h81);
					if (par_q)
						contrast_q <= nb;
					if (nb == 8'haf)
						on_q <= 1;
					if (nb == 8'hae)
						drive_on_q <= 1'b0;
				end
			end
		end
	end
endmodule // ops_panel_model

// *** hw/ops_host.sv ***
// Contract
// - after logic supply settles, hold reset low at least 3 us, then release
// - panel supply turns on no sooner than 3 us after reset went low
// - display-on sent after panel supply settles; drive starts 100 ms later
// - power down sends display-off before panel supply is switched off
// - wait a gap after panel supply off before logic supply off
// - logic supply never removed while panel supply is on
// - init starts display off, clock divide command and its parameter
// - then multiplex ratio command with 64-row parameter
// - then pre-charge period command with its parameter
// - then memory addressing mode command with page mode parameter
// - then segment remap, then reversed common scan direction
// - then common pins configuration command with its parameter
// - then colour mode command selecting monochrome normal power
// - then contrast command with its parameter
// - then page start command, then display offset zero
// - then normal display, then display follows memory
// - then common deselect level command with its parameter
// - init ends by clearing display memory, then display on
// - select line low means command byte, high means display data
// - chip select held low through every serial transfer
module ops_host #(
	parameter logic [ops_pkg::WAIT_W-1:0] VDD_SETL_CYC =
		ops_pkg::WAIT_W'(ops_pkg::VDD_SETL_CYC),
	parameter logic [ops_pkg::WAIT_W-1:0] VCC_SETL_CYC =
		ops_pkg::WAIT_W'(ops_pkg::VCC_SETL_CYC),
	parameter logic [ops_pkg::WAIT_W-1:0] DISP_ON_CYC  =
		ops_pkg::WAIT_W'(ops_pkg::DISP_ON_CYC),
	parameter logic [ops_pkg::WAIT_W-1:0] OFF_GAP_CYC  =
		ops_pkg::WAIT_W'(ops_pkg::OFF_GAP_CYC),
	// link half period in clocks; the default meets the module's timing
	parameter int                         HALF_CYC     = ops_pkg::HALF_CYC
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rstn,
	// apb slave
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [11:0]      paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	// display module pins
	output ops_pkg::ops_pins_t    panel_pins
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	ops_pkg::ops_state_t              state_q;
	logic [ops_pkg::WAIT_W-1:0]       wait_q;
	logic [4:0]                       idx_q;
	logic [2:0]                       page_q;
	logic [7:0]                       col_q;
	logic                             vdd_en_q;
	logic                             vcc_en_q;
	logic                             rst_n_q;
	logic                             busy_q;
	logic                             done_q;
	logic [4:0]                       step_q;
	logic [7:0]                       div_q;
	logic [7:0]                       shift_q;
	logic                             cs_n_q;
	logic                             dc_q;
	logic                             sclk_q;
	logic                             serial_data_input_q;
	logic                             tx_pend_q;
	logic [7:0]                       tx_byte_q;
	logic                             tx_dc_q;
	logic                             need;
	logic [7:0]                       go_byte;
	logic                             go_dc;
	logic                             go;
	logic                             tick;
	logic                             wr_en;
	logic                             up_req;
	logic                             dn_req;

	// ------------------------------------------------------------
	// apb slave
	// ------------------------------------------------------------
	// zero wait states: every access completes in its first access cycle
	assign pready = 1'b1;
	assign wr_en  = psel & penable & pwrite;
	assign up_req = wr_en && paddr == ops_pkg::REG_CTRL
		&& pwdata[ops_pkg::CTRL_UP_BIT];
	assign dn_req = wr_en && paddr == ops_pkg::REG_CTRL
		&& pwdata[ops_pkg::CTRL_DOWN_BIT];

	always_comb
	begin
		pslverr = 1'b0;
		prdata  = 32'h0000_0000;
		if (psel && penable)
		begin
			unique case (paddr)
				ops_pkg::REG_CTRL:   prdata = 32'h0000_0000;
				ops_pkg::REG_STATUS: prdata = {20'h00000, tx_pend_q,
					busy_q, rst_n_q, vcc_en_q, vdd_en_q,
					state_q == ops_pkg::S_ON, 2'h0, state_q};
				ops_pkg::REG_TX:     prdata = {23'h000000, tx_dc_q,
					tx_byte_q};
				default:             pslverr = 1'b1;
			endcase
		end
	end

	// a tx write while not ready is dropped; software polls pending
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			tx_pend_q <= 1'b0;
			tx_byte_q <= 8'h00;
			tx_dc_q   <= 1'b0;
		end
		else if (go && state_q == ops_pkg::S_ON)
			tx_pend_q <= 1'b0;
		else if (wr_en && paddr == ops_pkg::REG_TX && !tx_pend_q
			&& state_q == ops_pkg::S_ON)
		begin
			tx_pend_q <= 1'b1;
			tx_byte_q <= pwdata[7:0];
			tx_dc_q   <= pwdata[ops_pkg::TX_DC_BIT];
		end
	end

	// ------------------------------------------------------------
	// byte source
	// ------------------------------------------------------------
	always_comb
	begin
		need    = 1'b0;
		go_byte = 8'h00;
		go_dc   = 1'b0;
		unique case (state_q)
			ops_pkg::S_INIT:
			begin
				need    = 1'b1;
				go_byte = ops_pkg::INIT_SEQ[idx_q];
			end
			ops_pkg::S_CLEAR:
			begin
				need = 1'b1;
				if (col_q == 8'h00)
					go_byte = ops_pkg::CMD_PAGE | {5'h00, page_q};
				else if (col_q == 8'h01)
					go_byte = ops_pkg::CMD_COL_LO;
				else if (col_q == 8'h02)
					go_byte = ops_pkg::CMD_COL_HI;
				else
				begin
					go_byte = ops_pkg::CLEAR_BYTE;
					go_dc   = 1'b1;
				end
			end
			ops_pkg::S_DISP_ON:
			begin
				need    = 1'b1;
				go_byte = ops_pkg::CMD_DISP_ON;
			end
			ops_pkg::S_OFF_CMD:
			begin
				need    = 1'b1;
				go_byte = ops_pkg::CMD_DISP_OFF;
			end
			ops_pkg::S_ON:
			begin
				need    = tx_pend_q;
				go_byte = tx_byte_q;
				go_dc   = tx_dc_q;
			end
			default:
			begin
				need = 1'b0;
			end
		endcase
	end

	// one byte in flight at a time
	assign go = need & ~busy_q & ~done_q;

	// ------------------------------------------------------------
	// serial engine
	// ------------------------------------------------------------
	assign tick = busy_q && div_q == 8'(HALF_CYC - 1);

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			div_q <= 8'h00;
		else if (!busy_q || tick)
			div_q <= 8'h00;
		else
			div_q <= div_q + 8'h01;
	end

	// device samples on the rising edge; data moves on the falling one
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			busy_q  <= 1'b0;
			done_q  <= 1'b0;
			step_q  <= 5'h00;
			shift_q <= 8'h00;
			cs_n_q  <= 1'b1;
			dc_q    <= 1'b0;
			sclk_q  <= 1'b0;
			serial_data_input_q  <= 1'b0;
		end
		else
		begin
			done_q <= 1'b0;
			if (go)
			begin
				busy_q  <= 1'b1;
				step_q  <= 5'h00;
				cs_n_q  <= 1'b0;
				dc_q    <= go_dc;
				shift_q <= go_byte;
				serial_data_input_q  <= go_byte[7];
				sclk_q  <= 1'b0;
			end
			else if (tick)
			begin
				step_q <= step_q + 5'h01;
				if (step_q <= ops_pkg::STEP_LAST_BIT)
				begin
					if (!step_q[0])
						sclk_q <= 1'b1;
					else
					begin
						sclk_q  <= 1'b0;
						shift_q <= {shift_q[6:0], 1'b0};
						serial_data_input_q  <= shift_q[6];
					end
				end
				else if (step_q == ops_pkg::STEP_CS_OFF)
					cs_n_q <= 1'b1;
				else if (step_q == ops_pkg::STEP_DONE)
				begin
					busy_q <= 1'b0;
					done_q <= 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// power and init sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_q  <= ops_pkg::S_OFF;
			wait_q   <= '0;
			idx_q    <= 5'h00;
			page_q   <= 3'h0;
			col_q    <= 8'h00;
			vdd_en_q <= 1'b0;
			vcc_en_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end
		else
		begin
			if (wait_q != '0)
				wait_q <= wait_q - 1'b1;
			unique case (state_q)
				ops_pkg::S_OFF:
					if (up_req)
					begin
						vdd_en_q <= 1'b1;
						wait_q   <= VDD_SETL_CYC;
						state_q  <= ops_pkg::S_VDD_WAIT;
					end
				ops_pkg::S_VDD_WAIT:
					if (wait_q == '0)
					begin
						// reset is already low; time it from here
						rst_n_q <= 1'b0;
						wait_q  <= ops_pkg::RST_LOW_CYC;
						state_q <= ops_pkg::S_RST_LOW;
					end
				ops_pkg::S_RST_LOW:
					if (wait_q == '0)
					begin
						rst_n_q  <= 1'b1;
						vcc_en_q <= 1'b1;
						wait_q   <= VCC_SETL_CYC;
						state_q  <= ops_pkg::S_VCC_WAIT;
					end
				ops_pkg::S_VCC_WAIT:
					if (wait_q == '0)
					begin
						idx_q   <= 5'h00;
						state_q <= ops_pkg::S_INIT;
					end
				ops_pkg::S_INIT:
					if (done_q)
					begin
						// stream order
						if (idx_q == 5'(ops_pkg::INIT_LEN - 1))
						begin
							page_q  <= 3'h0;
							col_q   <= 8'h00;
							state_q <= ops_pkg::S_CLEAR;
						end
						else
							idx_q <= idx_q + 5'h01;
					end
				ops_pkg::S_CLEAR:
					if (done_q)
					begin
						if (col_q == ops_pkg::CLR_LAST)
						begin
							col_q <= 8'h00;
							if (page_q == ops_pkg::LAST_PAGE)
								state_q <= ops_pkg::S_DISP_ON;
							else
								page_q <= page_q + 3'h1;
						end
						else
							col_q <= col_q + 8'h01;
					end
				ops_pkg::S_DISP_ON:
					if (done_q)
					begin
						wait_q  <= DISP_ON_CYC;
						state_q <= ops_pkg::S_ON_WAIT;
					end
				ops_pkg::S_ON_WAIT:
					if (wait_q == '0)
						state_q <= ops_pkg::S_ON;
				ops_pkg::S_ON:
					if (dn_req && !busy_q && !tx_pend_q)
						state_q <= ops_pkg::S_OFF_CMD;
				ops_pkg::S_OFF_CMD:
					if (done_q)
					begin
						vcc_en_q <= 1'b0;
						wait_q   <= OFF_GAP_CYC;
						state_q  <= ops_pkg::S_OFF_GAP;
					end
				ops_pkg::S_OFF_GAP:
					if (wait_q == '0 && !vcc_en_q)
					begin
						vdd_en_q <= 1'b0;
						rst_n_q  <= 1'b0;
						state_q  <= ops_pkg::S_OFF;
					end
				default:
					state_q <= ops_pkg::S_OFF;
			endcase
		end
	end

	// ------------------------------------------------------------
	// pins
	// ------------------------------------------------------------
	assign panel_pins = '{
		logic_supply_en:    vdd_en_q,
		panel_supply_en:    vcc_en_q,
		panel_reset_line_n: rst_n_q,
		chip_sel_n:         cs_n_q,
		cmd_data_sel:       dc_q,
		serial_clk:         sclk_q,
		serial_data_input:  serial_data_input_q
	};

endmodule // ops_host

// *** hw/ops_pkg.sv ***
package ops_pkg;

	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 50;
	localparam int WAIT_W  = 23;

	localparam int T_RST_LOW_NS   = 3000;
	localparam int T_SUP_WAIT_NS  = 3000;
	localparam int T_HALF_NS      = 160;
	localparam int T_VDD_SETL_US  = 1000;
	localparam int T_VCC_SETL_US  = 1000;
	localparam int T_DISP_ON_MS   = 100;
	localparam int T_OFF_GAP_MS   = 100;

	localparam int RST_CYC_A = (T_RST_LOW_NS * CLK_MHZ + 999) / 1000;
	localparam int RST_CYC_B = (T_SUP_WAIT_NS * CLK_MHZ + 999) / 1000;
	localparam logic [WAIT_W-1:0] RST_LOW_CYC = WAIT_W'(
		(RST_CYC_A > RST_CYC_B) ? RST_CYC_A : RST_CYC_B);
	localparam int HALF_CYC = (T_HALF_NS * CLK_MHZ + 999) / 1000;
	localparam int VDD_SETL_CYC = T_VDD_SETL_US * CLK_MHZ;
	localparam int VCC_SETL_CYC = T_VCC_SETL_US * CLK_MHZ;
	localparam int DISP_ON_CYC  = T_DISP_ON_MS * CLK_MHZ * 1000;
	localparam int OFF_GAP_CYC  = T_OFF_GAP_MS * CLK_MHZ * 1000;

	// ------------------------------------------------------------
	// command bytes and init stream
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_DISP_OFF = 8'hae;
	localparam logic [7:0] CMD_DISP_ON  = 8'haf;
	localparam logic [7:0] CMD_PAGE     = 8'hb0;
	localparam logic [7:0] CMD_COL_LO   = 8'h00;
	localparam logic [7:0] CMD_COL_HI   = 8'h10;
	localparam logic [7:0] CLEAR_BYTE   = 8'h00;
	localparam int INIT_LEN = 24;
	localparam logic [7:0] INIT_SEQ [INIT_LEN] = '{
		8'hae, 8'hd5, 8'hf1, 8'ha8, 8'h3f, 8'hd9, 8'hf1, 8'h20,
		8'h02, 8'ha0, 8'hc8, 8'hda, 8'h12, 8'hd8, 8'h00, 8'h81,
		8'hcf, 8'hb0, 8'hd3, 8'h00, 8'ha6, 8'ha4, 8'hdb, 8'h3c};
	localparam logic [2:0] LAST_PAGE = 3'h7;
	localparam logic [7:0] CLR_HDR   = 8'h03;
	localparam logic [7:0] CLR_LAST  = 8'h82;

	// serial engine steps
	localparam logic [4:0] STEP_LAST_BIT = 5'h0f;
	localparam logic [4:0] STEP_CS_OFF   = 5'h11;
	localparam logic [4:0] STEP_DONE     = 5'h12;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [11:0] REG_CTRL   = 12'h000;
	localparam logic [11:0] REG_STATUS = 12'h004;
	localparam logic [11:0] REG_TX     = 12'h008;
	localparam int CTRL_UP_BIT   = 0;
	localparam int CTRL_DOWN_BIT = 1;
	localparam int TX_DC_BIT     = 8;

	typedef enum logic [3:0] {
		S_OFF, S_VDD_WAIT, S_RST_LOW, S_VCC_WAIT, S_INIT, S_CLEAR,
		S_DISP_ON, S_ON_WAIT, S_ON, S_OFF_CMD, S_OFF_GAP
	} ops_state_t;

	typedef struct packed {
		logic logic_supply_en;
		logic panel_supply_en;
		logic panel_reset_line_n;
		logic chip_sel_n;
		logic cmd_data_sel;
		logic serial_clk;
		logic serial_data_input;
	} ops_pins_t;

endpackage
